//--- logic/simd_vector_register_file.sv
// Vector register file with control/status, flags and AXI4-Lite access
// ==========================================================
// Overview of operation
// - Feature query result word reads with bit 25 set.
// - Outside 64-bit mode eight 128-bit vector registers, indices zero to seven.
// - In 64-bit mode sixteen vector registers are available.
// - Registers eight to fifteen only reachable through the extension prefix index bit.
// - An extension prefix without meaning is ignored; instruction runs unchanged.
// - Compatibility mode behaves like protected mode, eight registers.
// - One 32-bit control/status register governs the vector float operations.
// - Scalar operations touch only the lowest 32-bit lane.
// - Vector storage is separate; writes never alter other register sets.
// - Vector registers never feed memory address generation.
// - Loads and stores move 32, 64 or 128 bits.
// - Full store gives 16 bytes, register bits 7:0 at lowest address.
// - Some vector compares report through the processor flags register.
// - Usable in protected, real-address and virtual-8086 modes.
// - Width prefix bit selects a 64-bit general-purpose operand.
// - Eight 64-bit packed-integer registers exchange data with vector registers.
// - Control/status bits 31:16 reset to zero; non-zero write faults.
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`default_nettype none
module simd_vector_register_file
#(
    parameter int NUM_VEC = simd_vrf_pkg::NUM_VEC_ALL,
    parameter int NUM_PKD = simd_vrf_pkg::NUM_PKD_ALL
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AXI4-Lite write channels
    input wire logic [simd_vrf_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [simd_vrf_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Pipeline side
    input wire simd_vrf_pkg::cpu_mode_t cpu_mode,
    input wire simd_vrf_pkg::vec_req_t req,
    input wire simd_vrf_pkg::cmp_result_t cmp,
    output simd_vrf_pkg::vec_rsp_t rsp,
    output logic [31:0] simd_control_status_reg,
    output logic [31:0] processor_flags_reg
);
    import simd_vrf_pkg::*;

    // ==========================================================
    // Storage
    logic [VEC_W-1:0] vec_q [NUM_VEC];
    logic [PKD_W-1:0] pkd_q [NUM_PKD];
    logic [31:0] csr_q;
    logic [31:0] csr_d;
    logic [31:0] flags_q;
    logic [31:0] flags_d;
    vec_rsp_t rsp_q;
    vec_rsp_t rsp_d;

    // ==========================================================
    // Index resolution
    wire logic long_mode = (cpu_mode == MODE_LONG);
    // The prefix bit only widens the index in 64-bit mode; elsewhere it is dropped
    wire logic idx_hi = long_mode & req.ext_prefix & req.ext_idx_bit;
    wire logic [3:0] eff_idx = {idx_hi, req.idx};
    wire logic [VEC_W-1:0] vec_cur = vec_q[eff_idx];
    wire logic [7:0] cur_low_byte = vec_cur[7:0];
    wire logic [PKD_W-1:0] pkd_cur = pkd_q[req.pk_idx];

    // ==========================================================
    // Vector write path
    // No mode gates any operation, so every execution mode may use the file
    wire logic op_write = req.valid & (req.op == OP_WRITE);
    wire logic op_from_pkd = req.valid & (req.op == OP_FROM_PKD);
    wire logic op_from_gp = req.valid & (req.op == OP_FROM_GP);
    wire logic op_to_pkd = req.valid & (req.op == OP_TO_PKD);
    wire logic op_csr = req.valid & (req.op == OP_CSR_LOAD);
    wire logic vec_we = op_write | op_from_pkd | op_from_gp;
    // Scalar and narrow loads merge into the low lane and keep the rest
    wire logic [VEC_W-1:0] width_mask = (req.width == W32) ? MASK32 :
                                        (req.width == W64) ? MASK64 : MASK128;
    wire logic [VEC_W-1:0] gp_mask = req.operand_width_prefix_bit ? MASK64 : MASK32;
    wire logic [VEC_W-1:0] vec_src = op_from_pkd ? {{(VEC_W-PKD_W){1'b0}}, pkd_cur} : req.data;
    wire logic [VEC_W-1:0] vec_msk = op_from_pkd ? MASK64 : op_from_gp ? gp_mask : width_mask;
    wire logic [VEC_W-1:0] vec_new = (vec_cur & ~vec_msk) | (vec_src & vec_msk);

    // Data arrays carry no reset: their contents are undefined until written
    always_ff @(posedge clk) begin
        if (vec_we) begin
            vec_q[eff_idx] <= vec_new;
        end
        if (op_to_pkd) begin
            pkd_q[req.pk_idx] <= vec_cur[PKD_W-1:0];
        end
    end

    // ==========================================================
    // Read and store response
    wire logic [15:0] store_be = (req.width == W32) ? BE32 : (req.width == W64) ? BE64 : BE128;
    wire logic op_to_gp = req.valid & (req.op == OP_TO_GP);
    wire logic [VEC_W-1:0] gp_word = vec_cur & gp_mask;
    wire logic csr_ld_bad = req.data[31:16] != CSR_UPPER_ZERO;
    logic [15:0][7:0] store_bytes;

    // Byte 0 of the store is register bits 7:0; addresses ascend with byte index
    genvar gb;
    generate
        for (gb = 0; gb < 16; gb++) begin : g_store_byte
            assign store_bytes[gb] = vec_cur[8*gb +: 8];
        end
    endgenerate

    // Only data leaves here; no vector value reaches any address port
    assign rsp_d.valid = req.valid;
    assign rsp_d.store_byte = store_bytes;
    assign rsp_d.byte_en = (req.op == OP_READ) ? store_be : 16'h0000;
    assign rsp_d.gp_data = op_to_gp ? gp_word[63:0] : 64'h0000_0000_0000_0000;
    assign rsp_d.gp_fault = op_csr & csr_ld_bad;

    // ==========================================================
    // Processor flags, updated by compares
    assign flags_d = cmp.valid ? ((flags_q & ~((32'h1 << FLAG_OF) | (32'h1 << FLAG_SF) | (32'h1 << FLAG_AF)
                     | (32'h1 << FLAG_ZF) | (32'h1 << FLAG_PF) | (32'h1 << FLAG_CF)))
                     | ({31'h0, cmp.zf} << FLAG_ZF) | ({31'h0, cmp.pf} << FLAG_PF)
                     | ({31'h0, cmp.cf} << FLAG_CF)) : flags_q;

    // ==========================================================
    // AXI4-Lite slave
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic aw_have_q;
    logic w_have_q;
    logic [AXI_AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    wire logic aw_take = awvalid & awready_q;
    wire logic w_take = wvalid & wready_q;
    wire logic wr_fire = aw_have_q & w_have_q & ~bvalid_q;
    wire logic aw_have_d = aw_take | (aw_have_q & ~wr_fire);
    wire logic w_have_d = w_take | (w_have_q & ~wr_fire);
    wire logic bvalid_d = wr_fire | (bvalid_q & ~bready);
    wire logic ar_take = arvalid & arready_q;
    wire logic rvalid_d = ar_take | (rvalid_q & ~rready);
    logic [31:0] strb_mask;

    genvar gs;
    generate
        for (gs = 0; gs < 4; gs++) begin : g_strb
            assign strb_mask[8*gs +: 8] = {8{w_strb_q[gs]}};
        end
    endgenerate

    wire logic [31:0] csr_merged = (csr_q & ~strb_mask) | (w_data_q & strb_mask);
    wire logic axi_csr_hit = aw_addr_q == OFF_CSR;
    wire logic axi_csr_ok = axi_csr_hit & (csr_merged[31:16] == CSR_UPPER_ZERO);
    // Other words are read-only; writing them or an unmapped address answers SLVERR
    wire logic [1:0] bresp_d = wr_fire ? (axi_csr_ok ? RESP_OKAY : RESP_SLVERR) : bresp_q;
    // A pipeline load and a bus write in one cycle: the pipeline load wins
    assign csr_d = (op_csr & ~csr_ld_bad) ? req.data[31:0] :
                   (wr_fire & axi_csr_ok) ? csr_merged : csr_q;

    wire logic [31:0] status_w = {19'h0, long_mode ? CNT_LONG : CNT_LEGACY, 5'h0, cpu_mode};
    wire logic rd_hit = (araddr == OFF_CSR) | (araddr == OFF_FEATURE) | (araddr == OFF_STATUS)
                        | (araddr == OFF_FLAGS);
    wire logic [31:0] rd_word = (araddr == OFF_CSR) ? csr_q :
                                (araddr == OFF_FEATURE) ? FEATURE_VALUE :
                                (araddr == OFF_STATUS) ? status_w :
                                (araddr == OFF_FLAGS) ? flags_q : 32'h0000_0000;

    // ==========================================================
    // Control registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            csr_q <= CSR_RESET;
            flags_q <= FLAGS_RESET;
            rsp_q <= '0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            csr_q <= csr_d;
            flags_q <= flags_d;
            rsp_q <= rsp_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= ~aw_have_d;
            wready_q <= ~w_have_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (aw_take) begin
                aw_addr_q <= awaddr;
            end
            if (w_take) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (ar_take) begin
                rdata_q <= rd_hit ? rd_word : 32'h0000_0000;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;
    assign rsp = rsp_q;
    assign simd_control_status_reg = csr_q;
    assign processor_flags_reg = flags_q;

    // ==========================================================
    // Checks
    logic chk_arm_q;
    logic [3:0] chk_idx_q;
    logic [VEC_W-33:0] chk_hi_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chk_arm_q <= 1'b0;
        end else begin
            chk_arm_q <= op_write & (req.width == W32);
        end
    end

    always_ff @(posedge clk) begin
        chk_idx_q <= eff_idx;
        chk_hi_q <= vec_cur[VEC_W-1:32];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_bad_load;
        req.valid && req.op == OP_CSR_LOAD && req.data[31:16] != CSR_UPPER_ZERO;
    endsequence
    sequence s_feature_read;
        arvalid && arready_q && araddr == OFF_FEATURE;
    endsequence
    sequence s_resp_stall;
        bvalid_q && !bready;
    endsequence

    a_feature_bit_set: assert property (s_feature_read |=> rvalid_q && rdata_q[FEATURE_BIT])
        else $error("feature query bit not returned set");
    a_legacy_idx_limit: assert property (req.valid && cpu_mode != MODE_LONG |-> !eff_idx[3])
        else $error("upper register reached outside 64-bit mode");
    a_long_idx_ext: assert property (req.valid && long_mode && req.ext_prefix && req.ext_idx_bit
        |-> eff_idx[3])
        else $error("extension bit did not select upper register");
    a_scalar_lane_only: assert property (chk_arm_q |-> vec_q[chk_idx_q][VEC_W-1:32] == chk_hi_q)
        else $error("scalar write disturbed upper lanes");
    a_csr_upper_zero: assert property (csr_q[31:16] == CSR_UPPER_ZERO)
        else $error("control/status upper bits not zero");
    a_csr_bad_fault: assert property (s_bad_load |=> rsp_q.valid && rsp_q.gp_fault)
        else $error("bad control/status load did not fault");
    a_store_byte_order: assert property (req.valid && req.op == OP_READ |=>
        rsp_q.store_byte[0] == $past(cur_low_byte))
        else $error("store byte 0 is not register bits 7:0");
    a_store_width_be: assert property (req.valid && req.op == OP_READ && req.width == W32 |=>
        rsp_q.byte_en == BE32)
        else $error("32-bit store byte enables wrong");
    a_gp_narrow: assert property (op_to_gp && !req.operand_width_prefix_bit |=>
        rsp_q.gp_data[63:32] == 32'h0000_0000)
        else $error("narrow general-purpose move carried upper bits");
    a_flags_zf: assert property (cmp.valid |=> processor_flags_reg[FLAG_ZF] == $past(cmp.zf))
        else $error("compare result not in flags");
    a_bresp_hold: assert property (s_resp_stall |=> bvalid_q && $stable(bresp_q))
        else $error("write response dropped before ready");
endmodule
`default_nettype wire

//--- inc/simd_vrf_pkg.sv
// Shared constants, types and register map of the vector register file
`default_nettype none
package simd_vrf_pkg;
    // ==========================================================
    // Register map (AXI4-Lite byte addresses)
    localparam int AXI_AW = 4;
    localparam logic [AXI_AW-1:0] OFF_CSR = 4'h0;
    localparam logic [AXI_AW-1:0] OFF_FEATURE = 4'h4;
    localparam logic [AXI_AW-1:0] OFF_STATUS = 4'h8;
    localparam logic [AXI_AW-1:0] OFF_FLAGS = 4'hc;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Control/status and query values
    localparam logic [31:0] CSR_RESET = 32'h0000_1f80;
    localparam logic [15:0] CSR_UPPER_ZERO = 16'h0000;
    localparam int FEATURE_BIT = 25;
    localparam logic [31:0] FEATURE_VALUE = 32'h0200_0000;
    localparam logic [4:0] CNT_LONG = 5'h10;
    localparam logic [4:0] CNT_LEGACY = 5'h08;
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
    localparam int FLAG_CF = 0;
    localparam int FLAG_PF = 2;
    localparam int FLAG_AF = 4;
    localparam int FLAG_ZF = 6;
    localparam int FLAG_SF = 7;
    localparam int FLAG_OF = 11;
    // ==========================================================
    // Storage geometry
    localparam int VEC_W = 128;
    localparam int PKD_W = 64;
    localparam int NUM_VEC_ALL = 16;
    localparam int NUM_PKD_ALL = 8;
    localparam logic [VEC_W-1:0] MASK32 = 128'h0000_0000_0000_0000_0000_0000_ffff_ffff;
    localparam logic [VEC_W-1:0] MASK64 = 128'h0000_0000_0000_0000_ffff_ffff_ffff_ffff;
    localparam logic [VEC_W-1:0] MASK128 = 128'hffff_ffff_ffff_ffff_ffff_ffff_ffff_ffff;
    localparam logic [15:0] BE32 = 16'h000f;
    localparam logic [15:0] BE64 = 16'h00ff;
    localparam logic [15:0] BE128 = 16'hffff;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        MODE_REAL = 3'h0,
        MODE_V86 = 3'h1,
        MODE_PROT = 3'h2,
        MODE_COMPAT = 3'h3,
        MODE_LONG = 3'h4
    } cpu_mode_t;
    typedef enum logic [1:0] {W32 = 2'h0, W64 = 2'h1, W128 = 2'h2} xfer_width_t;
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_TO_PKD = 3'h2,
        OP_FROM_PKD = 3'h3,
        OP_TO_GP = 3'h4,
        OP_FROM_GP = 3'h5,
        OP_CSR_LOAD = 3'h6
    } vec_op_t;
    typedef struct packed {
        logic valid;
        vec_op_t op;
        logic ext_prefix;
        logic ext_idx_bit;
        logic operand_width_prefix_bit;
        logic [2:0] idx;
        logic [2:0] pk_idx;
        xfer_width_t width;
        logic [VEC_W-1:0] data;
    } vec_req_t;
    typedef struct packed {
        logic valid;
        logic [15:0][7:0] store_byte;
        logic [15:0] byte_en;
        logic [63:0] gp_data;
        logic gp_fault;
    } vec_rsp_t;
    typedef struct packed {
        logic valid;
        logic zf;
        logic pf;
        logic cf;
    } cmp_result_t;
endpackage
`default_nettype wire

//--- testbench/pipe_model.sv
// Behavioural model of the decode and execute pipeline that drives the register file
`default_nettype none
module pipe_model
    import simd_vrf_pkg::*;
(
    // Clock
    input wire logic clk,
    // Requests towards the register file
    output var simd_vrf_pkg::cpu_mode_t cpu_mode,
    output var simd_vrf_pkg::vec_req_t req,
    output var simd_vrf_pkg::cmp_result_t cmp,
    // Answers from the register file
    input wire simd_vrf_pkg::vec_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Idle state
    initial begin
        cpu_mode = MODE_PROT;
        req = '0;
        cmp = '0;
    end
    // ==========================================================
    // Issue one request; the answer is taken one edge later
    task automatic issue(input vec_op_t op, input logic [3:0] ix, input logic ext, input logic wb,
                         input logic [2:0] pk, input xfer_width_t w, input logic [127:0] d,
                         output vec_rsp_t r);
        @(posedge clk);
        req <= '{1'b1, op, ext, ix[3], wb, ix[2:0], pk, w, d}; // Upper index only with the prefix
        @(posedge clk);
        req.valid <= 1'b0;
        // Idle data is scrambled so a design cannot live off stale request fields
        req.data <= ~d;
        #1;
        r = rsp;
    endtask
    // One-cycle compare outcome pulse
    task automatic compare(input logic zf, input logic pf, input logic cf);
        @(posedge clk);
        cmp <= '{1'b1, zf, pf, cf};
        @(posedge clk);
        cmp.valid <= 1'b0;
        #1;
    endtask
    task automatic set_mode(input cpu_mode_t m);
        @(posedge clk);
        cpu_mode <= m;
    endtask
endmodule
`default_nettype wire

//--- testbench/test_simd_vector_register_file.sv
// Self-checking bench: AXI4-Lite register access and pipeline traffic
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_simd_vector_register_file;
    timeunit 1ns;
    timeprecision 1ps;
    import simd_vrf_pkg::*;
    logic clk = 0, reset_n = 0;
    logic [3:0] awaddr = '0, araddr = '0, wstrb = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, rdata, csr, flags;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    cpu_mode_t cpu_mode;
    vec_req_t req;
    cmp_result_t cmp;
    vec_rsp_t rsp, r;
    int n_fail = 0, tests_run = 0, cycles = 0;
    localparam logic [127:0] D0 = 128'h0f0e0d0c_0b0a0908_07060504_03020100;
    localparam logic [127:0] D1 = 128'h8877_6655_4433_2211_f0e1_d2c3_b4a5_9687;
    localparam logic [127:0] D2 = 128'h5a5a_a5a5_3c3c_c3c3_0ff0_f00f_1234_abcd;
    logic [127:0] e;
    simd_vector_register_file dut (.clk(clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cpu_mode(cpu_mode), .req(req),
        .cmp(cmp), .rsp(rsp), .simd_control_status_reg(csr), .processor_flags_reg(flags));
    pipe_model pm (.clk(clk), .cpu_mode(cpu_mode), .req(req), .cmp(cmp), .rsp(rsp));
    // ==========================================================
    // Clock, reset and hang guard
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // AXI4-Lite master; waits on the handshakes, never on a cycle count
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        `CHK({rresp, rdata}, {er, ed})
    endtask
    // Pipeline request; every request must answer one edge later
    task automatic vop(input vec_op_t op, input logic [3:0] ix, input logic ext, input logic wb,
                       input xfer_width_t w, input logic [127:0] d);
        pm.issue(op, ix, ext, wb, 3'h3, w, d, r);
        `CHK(r.valid, 1'b1)
    endtask
    // ==========================================================
    // Test sequence
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        axi_rd(OFF_CSR, CSR_RESET, RESP_OKAY);
        `CHK(csr[31:16], CSR_UPPER_ZERO)
        axi_rd(OFF_FEATURE, FEATURE_VALUE, RESP_OKAY);
        axi_rd(OFF_FLAGS, FLAGS_RESET, RESP_OKAY);
        axi_rd(4'h2, 32'h0000_0000, RESP_SLVERR);
        // Register count and usability in every mode
        for (int m = 0; m < 5; m++) begin
            pm.set_mode(cpu_mode_t'(m));
            axi_rd(OFF_STATUS, {19'h0, (m == 4) ? CNT_LONG : CNT_LEGACY, 5'h0, 3'(m)},
                   RESP_OKAY);
            vop(OP_WRITE, 4'h2, 1'b0, 1'b0, W128, D0 ^ 128'(m));
            vop(OP_READ, 4'h2, 1'b0, 1'b0, W128, '0);
            `CHK(r.store_byte, D0 ^ 128'(m))
        end
        pm.set_mode(MODE_PROT);
        // Control/status access and refused writes
        axi_wr(OFF_CSR, 32'h0000_ffc0, 4'hf, RESP_OKAY);
        axi_wr(OFF_CSR, 32'h0001_ffc0, 4'hf, RESP_SLVERR);
        // Byte strobes merge into the held word; only the strobed lanes change
        axi_wr(OFF_CSR, 32'hdead_be80, 4'h1, RESP_OKAY);
        axi_rd(OFF_CSR, 32'h0000_ff80, RESP_OKAY);
        axi_wr(OFF_CSR, 32'h00ff_11c0, 4'h5, RESP_SLVERR);
        axi_wr(OFF_CSR, 32'h1111_11c0, 4'h1, RESP_OKAY);
        axi_wr(OFF_FEATURE, 32'h0000_0000, 4'hf, RESP_SLVERR);
        axi_wr(4'h2, 32'h0000_0001, 4'hf, RESP_SLVERR);
        axi_rd(OFF_CSR, 32'h0000_ffc0, RESP_OKAY);
        // Widths, byte order and the scalar lane
        vop(OP_WRITE, 4'h1, 1'b0, 1'b0, W128, D0);
        vop(OP_READ, 4'h1, 1'b0, 1'b0, W128, '0);
        `CHK({r.store_byte[15], r.store_byte[0], r.byte_en}, {8'h0f, 8'h00, BE128})
        `CHK(r.store_byte, D0)
        vop(OP_WRITE, 4'h1, 1'b0, 1'b0, W32, {4{32'hdead_beef}});
        vop(OP_READ, 4'h1, 1'b0, 1'b0, W32, '0);
        `CHK({r.store_byte, r.byte_en}, {D0[127:32], 32'hdead_beef, BE32})
        vop(OP_WRITE, 4'h1, 1'b0, 1'b0, W64, {4{32'h1234_5678}});
        vop(OP_READ, 4'h1, 1'b0, 1'b0, W64, '0);
        `CHK({r.store_byte, r.byte_en}, {D0[127:64], 64'h1234_5678_1234_5678, BE64})
        // Prefix outside 64-bit mode lands on the low eight
        vop(OP_WRITE, 4'h9, 1'b1, 1'b0, W128, D1);
        vop(OP_READ, 4'h1, 1'b0, 1'b0, W128, '0);
        `CHK(r.store_byte, D1)
        pm.set_mode(MODE_LONG);
        vop(OP_WRITE, 4'h9, 1'b1, 1'b0, W128, D2);
        vop(OP_READ, 4'h9, 1'b1, 1'b0, W128, '0);
        `CHK(r.store_byte, D2)
        vop(OP_READ, 4'h1, 1'b0, 1'b0, W128, '0);
        `CHK(r.store_byte, D1)
        pm.set_mode(MODE_PROT);
        // Packed-integer and general-purpose exchange
        vop(OP_TO_PKD, 4'h1, 1'b0, 1'b0, W64, '0);
        vop(OP_WRITE, 4'h5, 1'b0, 1'b0, W128, D0);
        vop(OP_FROM_PKD, 4'h5, 1'b0, 1'b0, W64, '0);
        vop(OP_READ, 4'h5, 1'b0, 1'b0, W128, '0);
        e = {D0[127:64], D1[63:0]};
        `CHK(r.store_byte, e)
        vop(OP_TO_GP, 4'h5, 1'b0, 1'b1, W64, '0);
        `CHK(r.gp_data, D1[63:0])
        vop(OP_TO_GP, 4'h5, 1'b0, 1'b0, W32, '0);
        `CHK(r.gp_data, {32'h0, D1[31:0]})
        vop(OP_FROM_GP, 4'h5, 1'b0, 1'b0, W32, {4{32'h0bad_cafe}});
        vop(OP_READ, 4'h5, 1'b0, 1'b0, W128, '0);
        `CHK(r.store_byte, {e[127:32], 32'h0bad_cafe})
        `CHK({csr, flags}, {32'h0000_ffc0, FLAGS_RESET})
        // Control/status load from the pipeline
        vop(OP_CSR_LOAD, 4'h0, 1'b0, 1'b0, W32, 128'h0002_1f80);
        `CHK({r.gp_fault, csr}, {1'b1, 32'h0000_ffc0})
        vop(OP_CSR_LOAD, 4'h0, 1'b0, 1'b0, W32, 128'h0000_1f80);
        `CHK({r.gp_fault, csr}, {1'b0, 32'h0000_1f80})
        // Compare outcomes recorded in the flags
        pm.compare(1'b1, 1'b0, 1'b1);
        `CHK(flags, 32'h0000_0041)
        pm.compare(1'b0, 1'b1, 1'b0);
        axi_rd(OFF_FLAGS, 32'h0000_0004, RESP_OKAY);
        complete_run();
    end
endmodule
`default_nettype wire
